// ---- logic/adctc_map.vh ----
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCTC_MAP_VH
`define ADCTC_MAP_VH
`define ADCTC_OFF_CTRL0     3'h0
`define ADCTC_OFF_CTRL1     3'h1
`define ADCTC_OFF_TRIG      3'h2
`define ADCTC_OFF_RES_HI    3'h3
`define ADCTC_OFF_RES_LO    3'h4
`define ADCTC_OFF_STATUS    3'h5
`define ADCTC_RST_CTRL0     8'h00
`define ADCTC_RST_CTRL1     8'h00
`define ADCTC_RST_TRIG      5'h00
`define ADCTC_CTRL1_MASK    8'hF7
`define ADCTC_BIT_ENABLE    0
`define ADCTC_BIT_GO        1
`define ADCTC_BIT_NREF      2
`define ADCTC_BIT_FORMAT    7
`define ADCTC_CONV_PERIODS  4'hC
`define ADCTC_RC_DIV        7'h04
`define ADCTC_CH_NONE       5'h1F
`endif

// ---- logic/adctc_core.v ----
// converter control: trigger mux, edge detect, control registers, conversion sequencer
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "adctc_map.vh"
module adctc_core (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        clk_en,
  // register port
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // trigger sources, same clock
  input  wire        tmr0_ovf,
  input  wire        tmr1_ovf,
  input  wire        tmr2_match,
  input  wire        tmr3_ovf,
  input  wire        tmr4_match,
  input  wire        tmr5_ovf,
  input  wire        tmr6_match,
  input  wire [1:0]  cmp_out,
  input  wire [3:0]  logic_cell_out,
  input  wire [3:0]  capture_compare_out,
  // device state
  input  wire        sleep_mode,
  input  wire        rc_osc_tick,
  // analog side
  input  wire        sar_cmp,
  output reg         analog_power,
  output reg         sample_close,
  output reg  [5:0]  mux_sel,
  output reg         mux_connect,
  output reg         neg_ref_pin,
  output reg  [1:0]  pos_ref_src,
  output reg         conv_done_flag
);

////////////////////////////////////////////////////////////////////////
// reset release
reg        rst_s1_ff;
reg        rst_s2_ff;
always @(posedge sys_clk or negedge rst_b) begin
  if (!rst_b) begin
    rst_s1_ff <= 1'b0;
    rst_s2_ff <= 1'b0;
  end else begin
    rst_s1_ff <= 1'b1;
    rst_s2_ff <= rst_s1_ff;
  end
end
wire rst_n = rst_s2_ff;

////////////////////////////////////////////////////////////////////////
// registers and state
reg  [5:0] channel_sel_ff;
reg        go_ff;
reg        converter_enable_ff;
reg        result_format_ff;
reg  [2:0] conv_clock_sel_ff;
reg        neg_ref_sel_ff;
reg  [1:0] pos_ref_sel_ff;
reg  [4:0] trigger_source_sel_ff;
reg  [7:0] result_high_byte_ff;
reg  [7:0] result_low_byte_ff;
reg        trig_prev_ff;
reg  [6:0] div_cnt_ff;
reg  [3:0] period_cnt_ff;
reg  [9:0] sar_ff;
reg  [3:0] bit_idx_ff;
reg        last_bit_ff;

////////////////////////////////////////////////////////////////////////
// trigger selection
reg trig_sel;
always @* begin
  case (trigger_source_sel_ff)
    5'h01:   trig_sel = tmr4_match;
    5'h02:   trig_sel = tmr6_match;
    5'h03:   trig_sel = tmr0_ovf;
    5'h04:   trig_sel = tmr1_ovf;
    5'h05:   trig_sel = tmr2_match;
    5'h06:   trig_sel = cmp_out[0];
    5'h07:   trig_sel = cmp_out[1];
    5'h08:   trig_sel = logic_cell_out[0];
    5'h09:   trig_sel = logic_cell_out[1];
    5'h0A:   trig_sel = logic_cell_out[2];
    5'h0B:   trig_sel = logic_cell_out[3];
    5'h0C:   trig_sel = capture_compare_out[0];
    5'h0D:   trig_sel = capture_compare_out[1];
    5'h0E:   trig_sel = capture_compare_out[2];
    5'h0F:   trig_sel = capture_compare_out[3];
    5'h10:   trig_sel = tmr3_ovf;
    5'h11:   trig_sel = tmr5_ovf;
    default: trig_sel = 1'b0;
  endcase
end
// sampled on sysclk; edge ignored in sleep or while busy
wire trig_edge = trig_sel & ~trig_prev_ff;
wire trig_start = trig_edge & ~sleep_mode & ~go_ff;

////////////////////////////////////////////////////////////////////////
// conversion clock
reg [6:0] div_top;
always @* begin
  case (conv_clock_sel_ff)
    3'h0:    div_top = 7'h01;
    3'h1:    div_top = 7'h07;
    3'h2:    div_top = 7'h1F;
    3'h4:    div_top = 7'h03;
    3'h5:    div_top = 7'h0F;
    3'h6:    div_top = 7'h3F;
    default: div_top = `ADCTC_RC_DIV;
  endcase
end
wire use_rc = (conv_clock_sel_ff[1:0] == 2'h3);
wire tad_tick = use_rc ? rc_osc_tick : (div_cnt_ff >= div_top);

////////////////////////////////////////////////////////////////////////
// write decode and sequencer
wire wr_c0 = reg_wr & (reg_addr == `ADCTC_OFF_CTRL0);
wire sw_go = wr_c0 & reg_wdata[`ADCTC_BIT_GO];
wire sw_abort = wr_c0 & ~reg_wdata[`ADCTC_BIT_GO] & go_ff;
wire last_period = tad_tick & (period_cnt_ff == `ADCTC_CONV_PERIODS - 4'h1);
wire done = go_ff & last_period & ~sw_abort;
wire bit_phase = go_ff & tad_tick & (period_cnt_ff >= 4'h1) & (period_cnt_ff <= 4'hA);

// partial result: unconverted bits copy the last bit converted
reg [9:0] partial;
integer i;
always @* begin
  partial = sar_ff;
  for (i = 0; i < 10; i = i + 1) begin
    if (i < 10 - bit_idx_ff)
      partial[i] = last_bit_ff;
  end
end
wire [9:0] final_res = (sw_abort && bit_idx_ff != 4'h0) ? partial : sar_ff;

always @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    channel_sel_ff        <= 6'h00;
    go_ff                 <= 1'b0;
    converter_enable_ff   <= 1'b0;
    result_format_ff      <= 1'b0;
    conv_clock_sel_ff     <= 3'h0;
    neg_ref_sel_ff        <= 1'b0;
    pos_ref_sel_ff        <= 2'h0;
    trigger_source_sel_ff <= `ADCTC_RST_TRIG;
    result_high_byte_ff   <= 8'h00;
    result_low_byte_ff    <= 8'h00;
    trig_prev_ff          <= 1'b0;
    div_cnt_ff            <= 7'h00;
    period_cnt_ff         <= 4'h0;
    sar_ff                <= 10'h000;
    bit_idx_ff            <= 4'h0;
    last_bit_ff           <= 1'b0;
    conv_done_flag        <= 1'b0;
  end else if (clk_en) begin
    trig_prev_ff <= trig_sel;
    conv_done_flag <= 1'b0;
    if (wr_c0) begin
      channel_sel_ff      <= reg_wdata[7:2];
      converter_enable_ff <= reg_wdata[`ADCTC_BIT_ENABLE];
    end
    if (reg_wr && reg_addr == `ADCTC_OFF_CTRL1) begin
      result_format_ff  <= reg_wdata[`ADCTC_BIT_FORMAT];
      conv_clock_sel_ff <= reg_wdata[6:4];
      neg_ref_sel_ff    <= reg_wdata[`ADCTC_BIT_NREF];
      pos_ref_sel_ff    <= reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == `ADCTC_OFF_TRIG)
      trigger_source_sel_ff <= reg_wdata[4:0];
    div_cnt_ff <= (tad_tick || !go_ff) ? 7'h00 : div_cnt_ff + 7'h01;
    if (!go_ff && (sw_go || trig_start)) begin
      go_ff         <= 1'b1;
      period_cnt_ff <= 4'h0;
      sar_ff        <= 10'h000;
      bit_idx_ff    <= 4'h0;
    end else if (done || sw_abort) begin
      go_ff          <= 1'b0;
      conv_done_flag <= done;
      if (result_format_ff) begin
        result_high_byte_ff <= {6'h00, final_res[9:8]};
        result_low_byte_ff  <= final_res[7:0];
      end else begin
        result_high_byte_ff <= final_res[9:2];
        result_low_byte_ff  <= {final_res[1:0], 6'h00};
      end
    end else if (go_ff && tad_tick) begin
      period_cnt_ff <= period_cnt_ff + 4'h1;
      if (bit_phase) begin
        sar_ff[4'h9 - bit_idx_ff] <= sar_cmp;
        last_bit_ff <= sar_cmp;
        bit_idx_ff  <= bit_idx_ff + 4'h1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// analog controls
wire ch_valid = (channel_sel_ff <= 6'h05 && channel_sel_ff != 6'h03)
              | (channel_sel_ff >= 6'h0C && channel_sel_ff <= 6'h17)
              | (channel_sel_ff >= 6'h3C);
always @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    analog_power <= 1'b0;
    sample_close <= 1'b0;
    mux_sel      <= 6'h00;
    mux_connect  <= 1'b0;
    neg_ref_pin  <= 1'b0;
    pos_ref_src  <= 2'h0;
    reg_rdata    <= 8'h00;
  end else if (clk_en) begin
    analog_power <= converter_enable_ff;
    sample_close <= converter_enable_ff & ~go_ff;
    mux_sel      <= channel_sel_ff;
    mux_connect  <= converter_enable_ff & ch_valid;
    neg_ref_pin  <= converter_enable_ff & neg_ref_sel_ff;
    pos_ref_src  <= converter_enable_ff ? pos_ref_sel_ff : 2'h0;
    reg_rdata    <= 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ADCTC_OFF_CTRL0:  reg_rdata <= {channel_sel_ff, go_ff, converter_enable_ff};
        `ADCTC_OFF_CTRL1:  reg_rdata <= {result_format_ff, conv_clock_sel_ff, 1'b0,
                                         neg_ref_sel_ff, pos_ref_sel_ff};
        `ADCTC_OFF_TRIG:   reg_rdata <= {3'h0, trigger_source_sel_ff};
        `ADCTC_OFF_RES_HI: reg_rdata <= result_high_byte_ff;
        `ADCTC_OFF_RES_LO: reg_rdata <= result_low_byte_ff;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end
end

endmodule

// ---- verification/adctc_core_sva.sv ----
// port checks of the converter control
`timescale 1ns/1ps
module adctc_core_chk (
  // clock and reset
  input logic       sys_clk,
  input logic       rst_b,
  // register port
  input logic [2:0] reg_addr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  // analog side
  input logic       analog_power,
  input logic       sample_close,
  input logic [5:0] mux_sel,
  input logic       mux_connect,
  input logic       neg_ref_pin,
  input logic       conv_done_flag
);
  logic [7:0] gap_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // cycles since the last completion, parked at the top
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) gap_ff <= 8'hFF;
    else if (conv_done_flag) gap_ff <= 8'h00;
    else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
  end
  sequence s_rd_free; reg_rd && reg_addr > 3'h4; endsequence
  sequence s_rd_ctl1; reg_rd && reg_addr == 3'h1; endsequence
  a_unmapped_reads_zero: assert property (s_rd_free |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl1_gap_zero: assert property (s_rd_ctl1 |=> reg_rdata[3] == 1'b0)
    else $error("control1 bit3 not zero");
  a_done_single: assert property (conv_done_flag |=> !conv_done_flag)
    else $error("done pulse too long");
  a_done_spacing: assert property (conv_done_flag |-> gap_ff >= 8'd11)
    else $error("conversion shorter than twelve ticks");
  a_mux_off_disabled: assert property (mux_connect |-> analog_power)
    else $error("input connected while disabled");
  a_nref_off_disabled: assert property (neg_ref_pin |-> analog_power)
    else $error("reference pin used while disabled");
  a_mux_code_valid: assert property (mux_connect |->
    mux_sel inside {[6'h00:6'h02], 6'h04, 6'h05, [6'h0C:6'h17], [6'h3C:6'h3F]}) else $error("bad channel connected");
  a_sample_after_done: assert property (conv_done_flag && analog_power |-> ##[0:2] sample_close)
    else $error("sampling not resumed after done");
endmodule

// ---- verification/adctc_src_model.sv ----
// trigger sources: timers pulse once, level sources hold, rc oscillator runs free
`timescale 1ns/1ps
module adctc_src_model (
  // bench control
  input  wire         sys_clk,
  input  wire  [4:0]  sel,
  input  wire         hold,
  // sources
  output logic [16:0] src,
  output wire         rc_osc_tick
);
  logic       hold_ff = 1'b0;
  logic       tog_ff = 1'b0;
  logic [2:0] rc_ff = 3'h0;
  wire        pulse_kind = (sel <= 5'h05) || (sel >= 5'h10);
  always @(posedge sys_clk) begin
    hold_ff <= hold;
    tog_ff <= ~tog_ff;
    rc_ff <= rc_ff + 3'h1;
  end
  assign rc_osc_tick = (rc_ff == 3'h7);
  // no source selected: every line toggles while hold is high
  always @* begin
    src = 17'h0;
    if (sel == 5'h00) src = hold ? {17{tog_ff}} : 17'h0;
    else if (hold && !(pulse_kind && hold_ff)) src[sel - 5'h01] = 1'b1;
  end
endmodule

// ---- verification/tb.sv ----
// converter control bench: registers, clock select, format, triggers, abort
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       sar_cmp = 1'b0;
  logic [4:0] sel = 5'h00;
  logic       hold = 1'b0;
  wire  [7:0] reg_rdata;
  wire [16:0] src;
  wire        rc_tick;
  wire        done;
  wire  [1:0] pref;
  wire        mcon;
  int         err_total = 0;
  int         comparisons = 0;
  int         done_cnt = 0;
  int         cyc;
  int         dv [8] = '{2, 8, 32, 8, 4, 16, 64, 8};
  adctc_src_model i_src (.sys_clk(sys_clk), .sel(sel), .hold(hold), .src(src), .rc_osc_tick(rc_tick));
  adctc_core i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr0_ovf(src[2]),
    .tmr1_ovf(src[3]), .tmr2_match(src[4]), .tmr3_ovf(src[15]), .tmr4_match(src[0]), .tmr5_ovf(src[16]),
    .tmr6_match(src[1]), .cmp_out(src[6:5]), .logic_cell_out(src[10:7]), .capture_compare_out(src[14:11]),
    .sleep_mode(sleep_mode), .rc_osc_tick(rc_tick), .sar_cmp(sar_cmp), .analog_power(), .sample_close(),
    .mux_sel(), .mux_connect(mcon), .neg_ref_pin(), .pos_ref_src(pref), .conv_done_flag(done));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (done === 1'b1) done_cnt++;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK("reg_rdata", ex, reg_rdata)
    @(posedge sys_clk);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h00);
    `CHK("pos_ref_src", 2'h0, pref)
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'hF7);
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'h1F);
    wr(3'h5, 8'h55);
    rd(3'h5, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h01);
    repeat (8) @(posedge sys_clk);
    sar_cmp <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(3'h1, {1'b1, k[2:0], 4'h6});
      wr(3'h0, 8'h03);
      wait_done(cyc);
      `CHK("conv_len", 1'b1, cyc >= 11 * dv[k] && cyc <= 12 * dv[k] + 2)
    end
    `CHK("pos_ref_src", 2'h2, pref)
    `CHK("mux_connect", 1'b1, mcon)
    rd(3'h3, 8'h03);
    rd(3'h4, 8'hFF);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h03);
    wait_done(cyc);
    rd(3'h3, 8'hFF);
    rd(3'h4, 8'hC0);
    sar_cmp <= 1'b0;
    for (int k = 0; k < 18; k++) begin
      sel <= k[4:0];
      wr(3'h2, k[7:0]);
      hold <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(3'h0, k == 0 ? 8'h01 : 8'h03);
      if (k != 0) wait_done(cyc);
      repeat (4) @(posedge sys_clk);
      rd(3'h0, 8'h01);
      @(posedge sys_clk);
      hold <= 1'b0;
    end
    sleep_mode <= 1'b1;
    sel <= 5'h06;
    wr(3'h2, 8'h06);
    hold <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(3'h0, 8'h01);
    hold <= 1'b0;
    sleep_mode <= 1'b0;
    wr(3'h1, 8'h80);
    sar_cmp <= 1'b1;
    wr(3'h0, 8'h03);
    rd(3'h0, 8'h03);
    repeat (6) @(posedge sys_clk);
    wr(3'h0, 8'h01);
    repeat (30) @(posedge sys_clk);
    rd(3'h0, 8'h01);
    rd(3'h3, 8'h03);
    rd(3'h4, 8'hFF);
    `CHK("done_cnt", 26, done_cnt)
    wr(3'h0, 8'h0D);
    repeat (2) @(posedge sys_clk);
    `CHK("mux_connect", 1'b0, mcon)
    summarize;
  end
  initial begin
    #400000;
    err_total++;
    summarize;
  end
endmodule
bind adctc_core adctc_core_chk i_chk (.sys_clk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .analog_power,
  .sample_close, .mux_sel, .mux_connect, .neg_ref_pin, .conv_done_flag);
